// file: rtl/fifo2.v
// Purpose: two-entry valid/ready buffer
// Assumes: single clock, synchronous active-high reset
// Notes: output data comes straight from storage flops
`timescale 1ns/10ps
`default_nettype none

module fifo2 #(
   parameter W = 32,
   parameter D = 2
) (
   input wire i_mclk,
   input wire i_sys_rst,
   input wire i_in_valid,
   output wire o_in_ready,
   input wire [W-1:0] i_in_data,
   output wire o_out_valid,
   input wire i_out_ready,
   output wire [W-1:0] o_out_data,
   output wire o_empty
);
   reg [W-1:0] mem_q [0:D-1];
   reg wr_q;
   reg rd_q;
   reg [1:0] cnt_q;
   wire push = i_in_valid & o_in_ready;
   wire pop = o_out_valid & i_out_ready;

   assign o_in_ready = (cnt_q != D);
   assign o_out_valid = (cnt_q != 2'h0);
   assign o_empty = (cnt_q == 2'h0);
   assign o_out_data = mem_q[rd_q];

   always @(posedge i_mclk)
   begin
      if (push)
      begin
         mem_q[wr_q] <= i_in_data;
      end
   end

   always @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         cnt_q <= 2'h0;
      end
      else
      begin
         if (push)
         begin
            wr_q <= ~wr_q;
         end
         if (pop)
         begin
            rd_q <= ~rd_q;
         end
         if (push & ~pop)
         begin
            cnt_q <= cnt_q + 2'h1;
         end
         else if (pop & ~push)
         begin
            cnt_q <= cnt_q - 2'h1;
         end
      end
   end
endmodule // fifo2

`default_nettype wire

// file: rtl/flash_seq_map.vh
// Purpose: constants of the erase and program sequencer
// Assumes: included by its bare name from rtl files
// Notes: times are in microseconds, clock rate in MHz
`ifndef FLASH_SEQ_MAP_VH
`define FLASH_SEQ_MAP_VH

`define OP_WRITE_ENABLE 8'h06
`define OP_SECTOR_ERASE 8'h20
`define OP_HALF_BLOCK_ERASE 8'h52
`define OP_BLOCK_ERASE 8'hD8
`define OP_CHIP_ERASE_A 8'h60
`define OP_CHIP_ERASE_B 8'hC7
`define OP_PAGE_PROGRAM 8'h02
`define OP_QUAD_PAGE_PROGRAM 8'h32
`define OP_FOUR_LINE_ENTER 8'h38
`define OP_FOUR_LINE_EXIT 8'hFF

// Byte counts seen at chip select rise
`define LEN_OPCODE 3'h1
`define LEN_ADDR 3'h4
`define LEN_DATA 3'h5

// Erase span kinds
`define KIND_SECTOR 2'h0
`define KIND_HALF_BLOCK 2'h1
`define KIND_BLOCK 2'h2
`define KIND_CHIP 2'h3

// Address field positions
`define SECTOR_LSB 12
`define HALF_BLOCK_LSB 15
`define BLOCK_LSB 16
`define PAGE_LSB 8

// Reset values
`define WEL_RST 1'b0
`define FOUR_LINE_RST 1'b0

// Cycle times and clock rate
`define CLK_MHZ 100
`define SECTOR_ERASE_TIME_US 1000
`define HALF_BLOCK_ERASE_TIME_US 2000
`define BLOCK_ERASE_TIME_US 4000
`define CHIP_ERASE_TIME_US 100000
`define PAGE_PROGRAM_TIME_US 500

`endif

// file: rtl/serial_flash_erase_program.v
// Purpose: erase and program command sequencer of a serial flash
// Assumes: link pins sampled by i_mclk, serial clock far slower
// Notes: array itself lives outside; writes pass a two-entry buffer
`timescale 1ns/10ps
`default_nettype none

`include "flash_seq_map.vh"

module serial_flash_erase_program #(
   parameter [31:0] SECTOR_ERASE_CYC =
      `SECTOR_ERASE_TIME_US * `CLK_MHZ,
   parameter [31:0] HALF_BLOCK_ERASE_CYC =
      `HALF_BLOCK_ERASE_TIME_US * `CLK_MHZ,
   parameter [31:0] BLOCK_ERASE_CYC =
      `BLOCK_ERASE_TIME_US * `CLK_MHZ,
   parameter [31:0] CHIP_ERASE_CYC =
      `CHIP_ERASE_TIME_US * `CLK_MHZ,
   parameter [31:0] PAGE_PROGRAM_CYC =
      `PAGE_PROGRAM_TIME_US * `CLK_MHZ
) (
   input wire i_mclk,
   input wire i_sys_rst,
   input wire i_sclk,
   input wire i_cs_n,
   input wire [3:0] i_io,
   input wire [4:0] i_protect_level,
   input wire i_quad_enable,
   input wire i_mem_ready,
   output wire o_mem_valid,
   output wire [23:0] o_mem_addr,
   output wire [7:0] o_mem_data,
   output reg o_erase_req,
   output reg [1:0] o_erase_kind,
   output reg [23:0] o_erase_base,
   output wire o_write_in_progress,
   output wire o_write_enable_latch,
   output wire o_four_line_mode
);
   localparam S_IDLE = 2'h0;
   localparam S_ERASE = 2'h1;
   localparam S_DRAIN = 2'h2;
   localparam S_PWAIT = 2'h3;

   // Protected region grows down from the top, doubling from 64K per level
   function prot_hit;
      input [23:0] a;
      input [4:0] lvl;
      reg [8:0] thr;
      begin
         thr = 9'h100 - (9'h001 << (lvl - 5'h1));
         if (lvl == 5'h0)
            prot_hit = 1'b0;
         else if (lvl > 5'h8)
            prot_hit = 1'b1;
         else
            prot_hit = ({1'b0, a[23:16]} >= thr);
      end
   endfunction

   function [23:0] erase_base;
      input [23:0] a;
      input [1:0] kind;
      begin
         case (kind)
            `KIND_SECTOR:
               erase_base = a & (24'hFFFFFF << `SECTOR_LSB);
            `KIND_HALF_BLOCK:
               erase_base = a & (24'hFFFFFF << `HALF_BLOCK_LSB);
            `KIND_BLOCK:
               erase_base = a & (24'hFFFFFF << `BLOCK_LSB);
            default:
               erase_base = 24'h000000;
         endcase
      end
   endfunction

   function is_prog;
      input [7:0] op;
      begin
         is_prog = (op == `OP_PAGE_PROGRAM) |
            (op == `OP_QUAD_PAGE_PROGRAM);
      end
   endfunction

   reg sclk_s1_q, sclk_s2_q, sclk_s3_q;
   reg cs_s1_q, cs_s2_q, cs_s3_q;
   reg [3:0] io_s1_q, io_s2_q;
   reg [7:0] sh_q;
   reg [3:0] bits_q;
   reg [2:0] nbytes_q;
   reg [7:0] op_q;
   reg [23:0] addr_q;
   reg [7:0] pg_ptr_q;
   reg [255:0] mask_q;
   reg [7:0] page_mem [0:255];
   reg blocked_q;
   reg wel_q;
   reg four_line_q;
   reg wip_q;
   reg [1:0] state_q;
   reg [31:0] timer_q;
   reg [7:0] idx_q;

   wire sclk_rise = sclk_s2_q & ~sclk_s3_q;
   wire cs_rise = cs_s2_q & ~cs_s3_q;
   wire cs_fall = ~cs_s2_q & cs_s3_q;
   wire capture = ~cs_s2_q & ~blocked_q & sclk_rise;
   // Outside four-line mode the address of a 32H stays on line 0; only its data goes wide
   wire wide = four_line_q |
      ((op_q == `OP_QUAD_PAGE_PROGRAM) &
       (nbytes_q >= `LEN_ADDR));
   wire [7:0] sh_d = wide ? {sh_q[3:0], io_s2_q} :
      {sh_q[6:0], io_s2_q[0]};
   wire [3:0] nbits = bits_q + (wide ? 4'h4 : 4'h1);
   wire byte_done = (nbits == 4'h8);
   wire data_byte = is_prog(op_q) & (nbytes_q >= `LEN_ADDR);
   wire boundary = (bits_q == 4'h0);
   wire erase_op = (op_q == `OP_SECTOR_ERASE) |
      (op_q == `OP_HALF_BLOCK_ERASE) | (op_q == `OP_BLOCK_ERASE);
   wire chip_op = (op_q == `OP_CHIP_ERASE_A) |
      (op_q == `OP_CHIP_ERASE_B);
   wire [1:0] kind = (op_q == `OP_SECTOR_ERASE) ? `KIND_SECTOR :
      (op_q == `OP_HALF_BLOCK_ERASE) ? `KIND_HALF_BLOCK :
      (op_q == `OP_BLOCK_ERASE) ? `KIND_BLOCK : `KIND_CHIP;
   wire [23:0] base = erase_base(addr_q, kind);
   wire erase_ok = erase_op & wel_q & boundary &
      (nbytes_q == `LEN_ADDR);
   wire chip_ok = chip_op & wel_q & boundary &
      (nbytes_q == `LEN_OPCODE);
   // Without the latch a write command does nothing
   wire prog_ok = is_prog(op_q) & wel_q & boundary &
      (nbytes_q == `LEN_DATA) &
      ((op_q == `OP_PAGE_PROGRAM) | i_quad_enable);
   wire cmd_end = cs_rise & ~blocked_q & (state_q == S_IDLE);
   wire [31:0] erase_cyc = (kind == `KIND_SECTOR) ? SECTOR_ERASE_CYC :
      (kind == `KIND_HALF_BLOCK) ? HALF_BLOCK_ERASE_CYC :
      (kind == `KIND_BLOCK) ? BLOCK_ERASE_CYC : CHIP_ERASE_CYC;

   wire buf_in_ready;
   wire buf_empty;
   wire push = (state_q == S_DRAIN) & mask_q[idx_q];
   wire [31:0] buf_out;

   fifo2 #(
      .W(32),
      .D(2)
   ) u_buf (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_in_valid(push),
      .o_in_ready(buf_in_ready),
      .i_in_data({addr_q[23:8], idx_q, page_mem[idx_q]}),
      .o_out_valid(o_mem_valid),
      .i_out_ready(i_mem_ready),
      .o_out_data(buf_out),
      .o_empty(buf_empty)
   );

   assign o_mem_addr = buf_out[31:8];
   assign o_mem_data = buf_out[7:0];
   assign o_write_in_progress = wip_q;
   assign o_write_enable_latch = wel_q;
   assign o_four_line_mode = four_line_q;

   // Pins come from the host clock domain
   always @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         sclk_s1_q <= 1'b0;
         sclk_s2_q <= 1'b0;
         sclk_s3_q <= 1'b0;
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         cs_s3_q <= 1'b1;
         io_s1_q <= 4'h0;
         io_s2_q <= 4'h0;
      end
      else
      begin
         sclk_s1_q <= i_sclk;
         sclk_s2_q <= sclk_s1_q;
         sclk_s3_q <= sclk_s2_q;
         cs_s1_q <= i_cs_n;
         cs_s2_q <= cs_s1_q;
         cs_s3_q <= cs_s2_q;
         io_s1_q <= i_io;
         io_s2_q <= io_s1_q;
      end
   end

   // Page buffer storage, no reset needed
   always @(posedge i_mclk)
   begin
      if (capture & byte_done & data_byte)
      begin
         page_mem[pg_ptr_q] <= sh_d;
      end
   end

   always @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         sh_q <= 8'h00;
         bits_q <= 4'h0;
         nbytes_q <= 3'h0;
         op_q <= 8'h00;
         addr_q <= 24'h000000;
         pg_ptr_q <= 8'h00;
         mask_q <= {256{1'b0}};
         blocked_q <= 1'b0;
      end
      else if (cs_fall)
      begin
         bits_q <= 4'h0;
         nbytes_q <= 3'h0;
         // A command begun while busy is dropped whole
         blocked_q <= (state_q != S_IDLE);
         if (state_q == S_IDLE)
         begin
            mask_q <= {256{1'b0}};
         end
      end
      else if (capture)
      begin
         sh_q <= sh_d;
         bits_q <= byte_done ? 4'h0 : nbits;
         if (byte_done)
         begin
            if (nbytes_q != `LEN_DATA)
            begin
               nbytes_q <= nbytes_q + 3'h1;
            end
            if (nbytes_q == 3'h0)
            begin
               op_q <= sh_d;
            end
            else if (nbytes_q < `LEN_ADDR)
            begin
               addr_q <= {addr_q[15:0], sh_d};
               pg_ptr_q <= sh_d;
            end
            else if (data_byte)
            begin
               mask_q[pg_ptr_q] <= 1'b1;
               pg_ptr_q <= pg_ptr_q + 8'h01;
            end
         end
      end
   end

   always @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         wel_q <= `WEL_RST;
         four_line_q <= `FOUR_LINE_RST;
         wip_q <= 1'b0;
         state_q <= S_IDLE;
         timer_q <= 32'h00000000;
         idx_q <= 8'h00;
         o_erase_req <= 1'b0;
         o_erase_kind <= `KIND_SECTOR;
         o_erase_base <= 24'h000000;
      end
      else
      begin
         o_erase_req <= 1'b0;
         case (state_q)
            S_IDLE:
            begin
               if (cmd_end & boundary & (nbytes_q == `LEN_OPCODE))
               begin
                  if (op_q == `OP_WRITE_ENABLE)
                     wel_q <= 1'b1;
                  if ((op_q == `OP_FOUR_LINE_ENTER) & i_quad_enable)
                     four_line_q <= 1'b1;
                  if (op_q == `OP_FOUR_LINE_EXIT)
                     four_line_q <= 1'b0;
               end
               if (cmd_end & (erase_ok | chip_ok))
               begin
                  if (chip_ok & (i_protect_level != 5'h0))
                  begin
                     wel_q <= wel_q;
                  end
                  else if (erase_ok & prot_hit(base, i_protect_level))
                  begin
                     wel_q <= 1'b0;
                  end
                  else
                  begin
                     // Erase begins without further host action
                     state_q <= S_ERASE;
                     wip_q <= 1'b1;
                     timer_q <= erase_cyc;
                     o_erase_req <= 1'b1;
                     o_erase_kind <= kind;
                     o_erase_base <= base;
                  end
               end
               if (cmd_end & prog_ok)
               begin
                  if (prot_hit(addr_q, i_protect_level))
                  begin
                     wel_q <= 1'b0;
                  end
                  else
                  begin
                     state_q <= S_DRAIN;
                     wip_q <= 1'b1;
                     idx_q <= 8'h00;
                  end
               end
            end
            S_ERASE:
            begin
               if (timer_q <= 32'h00000001)
               begin
                  state_q <= S_IDLE;
                  wip_q <= 1'b0;
                  wel_q <= 1'b0;
               end
               else
               begin
                  timer_q <= timer_q - 32'h00000001;
               end
            end
            S_DRAIN:
            begin
               // Untouched bytes are skipped, not written as ones
               if (~mask_q[idx_q] | buf_in_ready)
               begin
                  idx_q <= idx_q + 8'h01;
                  if (idx_q == 8'hFF)
                  begin
                     state_q <= S_PWAIT;
                     timer_q <= PAGE_PROGRAM_CYC;
                  end
               end
            end
            S_PWAIT:
            begin
               if (timer_q > 32'h00000001)
               begin
                  timer_q <= timer_q - 32'h00000001;
               end
               else if (buf_empty)
               begin
                  // Array must have taken every byte first
                  state_q <= S_IDLE;
                  wip_q <= 1'b0;
                  wel_q <= 1'b0;
               end
            end
            default:
            begin
               state_q <= S_IDLE;
               wip_q <= 1'b0;
            end
         endcase
      end
   end
endmodule // serial_flash_erase_program

`default_nettype wire

// file: test/flash_host_model.sv
// Purpose: host serial controller driving the flash link
// Assumes: each serial clock phase lasts 4 system clocks
// Notes: unused lines toggle so stale values never look valid
`timescale 1ns/10ps
`default_nettype none
module flash_host_model (
   input wire logic i_mclk,
   output logic o_sclk,
   output logic o_cs_n,
   output logic [3:0] o_io
);
   initial
   begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_io = 4'h0;
   end
   function automatic logic [7:0] pat(input int i);
      pat = i[7:0] + ((i >= 256) ? 8'h40 : 8'h00);
   endfunction
   task automatic tick(input logic [3:0] v);
      o_io <= v;
      o_sclk <= 1'b0;
      repeat (4) @(posedge i_mclk);
      o_sclk <= 1'b1;
      repeat (4) @(posedge i_mclk);
   endtask
   task automatic put(input logic [7:0] b, input logic q);
      int i;
      if (q)
      begin
         tick(b[7:4]);
         tick(b[3:0]);
      end
      else
         for (i = 7; i >= 0; i--)
            tick({~o_io[3:1], b[i]});
   endtask
   task automatic send(input logic [7:0] op, input int na,
      input logic [23:0] a, input int nd, input int xb, input logic qd,
      input logic ql);
      int i;
      o_cs_n <= 1'b0;
      repeat (4) @(posedge i_mclk);
      put(op, ql);
      for (i = 0; i < na; i++)
         put(a[23-8*i -: 8], ql);
      for (i = 0; i < nd; i++)
         put(pat(i), qd | ql);
      for (i = 0; i < xb; i++)
         tick(~o_io);
      o_sclk <= 1'b0;
      repeat (4) @(posedge i_mclk);
      o_cs_n <= 1'b1;
      o_io <= ~o_io;
      repeat (12) @(posedge i_mclk);
   endtask
endmodule // flash_host_model
`default_nettype wire

// file: test/serial_flash_erase_program_props.sv
// Purpose: port checks of the erase and program sequencer
// Assumes: bound to the top module, one clock domain
// Notes: erase base and kind are sampled with the request pulse
`timescale 1ns/10ps
`default_nettype none
`include "flash_seq_map.vh"
module serial_flash_erase_program_props (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_cs_n,
   input wire logic [4:0] i_protect_level,
   input wire logic i_mem_ready,
   input wire logic o_mem_valid,
   input wire logic [23:0] o_mem_addr,
   input wire logic [7:0] o_mem_data,
   input wire logic o_erase_req,
   input wire logic [1:0] o_erase_kind,
   input wire logic [23:0] o_erase_base,
   input wire logic o_write_in_progress,
   input wire logic o_write_enable_latch
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_sys_rst);
   req_pulse_a: assert property (o_erase_req |=> !o_erase_req)
      else $error("erase request longer than one cycle");
   req_busy_a: assert property (
      o_erase_req |-> ##[0:1] o_write_in_progress)
      else $error("erase request without busy flag");
   req_select_a: assert property (o_erase_req |-> i_cs_n)
      else $error("erase request while selected");
   base_align_a: assert property (
      o_erase_req |-> o_erase_base[11:0] == 12'h000)
      else $error("erase base not sector aligned");
   chip_free_a: assert property (
      o_erase_req && o_erase_kind == `KIND_CHIP |->
      i_protect_level == 5'h00 && o_erase_base == 24'h000000)
      else $error("chip erase under protection");
   done_latch_a: assert property (
      $fell(o_write_in_progress) |-> !o_write_enable_latch)
      else $error("latch still set after cycle end");
   mem_hold_a: assert property (
      o_mem_valid && !i_mem_ready |=> o_mem_valid &&
      $stable(o_mem_addr) && $stable(o_mem_data))
      else $error("program byte changed while stalled");
   mem_busy_a: assert property (o_mem_valid |-> o_write_in_progress)
      else $error("program byte outside busy cycle");
   latch_rise_a: assert property (
      $rose(o_write_enable_latch) |-> i_cs_n)
      else $error("latch set while selected");
endmodule // serial_flash_erase_program_props
`default_nettype wire

// file: test/serial_flash_erase_program_test.sv
// Purpose: self-checking bench of the erase and program sequencer
// Assumes: short cycle counts, array side stalls every third cycle
// Notes: requests and program bytes are logged as they leave
`timescale 1ns/10ps
`default_nettype none
`include "flash_seq_map.vh"
module serial_flash_erase_program_test;
   logic i_mclk, i_sys_rst, i_mem_ready, i_quad_enable, ql;
   logic [4:0] i_protect_level;
   logic sclk, cs_n, mem_valid, erase_req, write_in_progress, write_enable_latch, four_line;
   logic [3:0] io;
   logic [23:0] mem_addr, erase_base;
   logic [7:0] mem_data;
   logic [1:0] erase_kind;
   logic [23:0] got_a[$];
   logic [7:0] got_d[$];
   logic [7:0] ops[5] = '{8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7};
   logic [1:0] kinds[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
   logic [23:0] bases[5] = '{24'h12B000, 24'h128000, 24'h120000, 0, 0};
   int num_errors = 0, total_checks = 0, cycles = 0, reqs = 0, r0, k, j;
   initial
   begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   flash_host_model host_inst (.i_mclk(i_mclk), .o_sclk(sclk),
      .o_cs_n(cs_n), .o_io(io));
   serial_flash_erase_program #(.SECTOR_ERASE_CYC(60),
      .HALF_BLOCK_ERASE_CYC(80), .BLOCK_ERASE_CYC(100),
      .CHIP_ERASE_CYC(3000), .PAGE_PROGRAM_CYC(50))
      serial_flash_erase_program_inst (.i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_io(io),
      .i_protect_level(i_protect_level), .i_quad_enable(i_quad_enable),
      .i_mem_ready(i_mem_ready), .o_mem_valid(mem_valid),
      .o_mem_addr(mem_addr), .o_mem_data(mem_data),
      .o_erase_req(erase_req), .o_erase_kind(erase_kind),
      .o_erase_base(erase_base), .o_write_in_progress(write_in_progress),
      .o_write_enable_latch(write_enable_latch), .o_four_line_mode(four_line));
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge i_mclk)
   begin
      cycles++;
      if (erase_req === 1'b1)
         reqs++;
      if (mem_valid === 1'b1 && i_mem_ready === 1'b1)
      begin
         got_a.push_back(mem_addr);
         got_d.push_back(mem_data);
      end
      i_mem_ready <= (cycles % 3 != 0);
      if (cycles == 60000)
      begin
         num_errors++;
         end_of_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmd(input logic [7:0] op, input int na,
      input logic [23:0] a, input int nd, input int xb, input logic qd);
      host_inst.send(op, na, a, nd, xb, qd, ql);
   endtask
   task automatic write_enable_cmd();
      cmd(`OP_WRITE_ENABLE, 0, 0, 0, 0, 0);
   endtask
   task automatic idle();
      int n;
      for (n = 0; write_in_progress !== 1'b0 && n < 5000; n++)
         @(posedge i_mclk);
   endtask
   initial
   begin
      i_sys_rst = 1'b1;
      i_protect_level = 5'h00;
      i_quad_enable = 1'b0;
      ql = 1'b0;
      repeat (12) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      repeat (4) @(posedge i_mclk);
      chk({write_in_progress, write_enable_latch, four_line, mem_valid}, 4'h0);
      cmd(`OP_SECTOR_ERASE, 3, 24'h12B456, 0, 0, 0);
      chk(reqs, 0);
      $display("test 1 done");
      for (k = 0; k < 5; k++)
      begin
         write_enable_cmd();
         r0 = reqs;
         cmd(ops[k], (k < 3) ? 3 : 0, 24'h12B456, 0, 0, 0);
         chk(reqs - r0, 1);
         chk({erase_kind, erase_base}, {kinds[k], bases[k]});
         chk(write_in_progress, 1'b1);
         if (k == 4)
         begin
            write_enable_cmd();
            cmd(`OP_SECTOR_ERASE, 3, 24'h000000, 0, 0, 0);
            chk(reqs - r0, 1);
         end
         idle();
         chk({write_in_progress, write_enable_latch}, 2'b00);
      end
      $display("test 2 done");
      write_enable_cmd();
      r0 = reqs;
      cmd(`OP_SECTOR_ERASE, 3, 24'h001000, 0, 3, 0);
      cmd(`OP_BLOCK_ERASE, 2, 24'h001000, 0, 0, 0);
      cmd(`OP_PAGE_PROGRAM, 3, 24'h001000, 1, 5, 0);
      chk(reqs - r0, 0);
      chk(got_a.size(), 0);
      chk({write_in_progress, write_enable_latch}, 2'b01);
      i_protect_level <= 5'h01;
      cmd(`OP_CHIP_ERASE_A, 0, 0, 0, 0, 0);
      chk({reqs - r0, write_enable_latch}, 1);
      cmd(`OP_HALF_BLOCK_ERASE, 3, 24'hFF8000, 0, 0, 0);
      chk({reqs - r0, write_enable_latch}, 0);
      write_enable_cmd();
      cmd(`OP_PAGE_PROGRAM, 3, 24'hFF0000, 1, 0, 0);
      idle();
      chk({got_a.size(), write_enable_latch}, 0);
      i_protect_level <= 5'h00;
      $display("test 3 done");
      write_enable_cmd();
      // Page is programmed once; overflow exercises last-256 retention
      cmd(`OP_PAGE_PROGRAM, 3, 24'h0012F0, 260, 0, 0);
      idle();
      chk(got_a.size(), 256);
      for (k = 0; k < 256; k++)
      begin
         j = (k - 'hF0) & 'hFF;
         j = (j < 4) ? j + 256 : j;
         chk(got_a[k], 24'h001200 | k);
         chk(got_d[k], host_inst.pat(j));
      end
      chk(write_enable_latch, 1'b0);
      $display("test 4 done");
      got_a.delete();
      got_d.delete();
      write_enable_cmd();
      cmd(`OP_QUAD_PAGE_PROGRAM, 3, 24'h0034FE, 3, 0, 1);
      cmd(`OP_FOUR_LINE_ENTER, 0, 0, 0, 0, 0);
      chk({got_a.size(), write_enable_latch, four_line}, 2'b10);
      i_quad_enable <= 1'b1;
      cmd(`OP_QUAD_PAGE_PROGRAM, 3, 24'h0034FE, 3, 0, 1);
      idle();
      chk(got_a.size(), 3);
      chk({got_a[0], got_d[0]}, {24'h003400, 8'h02});
      chk({got_a[1], got_d[1]}, {24'h0034FE, 8'h00});
      chk({got_a[2], got_d[2]}, {24'h0034FF, 8'h01});
      $display("test 5 done");
      write_enable_cmd();
      cmd(`OP_FOUR_LINE_ENTER, 0, 0, 0, 0, 0);
      chk({four_line, write_enable_latch}, 2'b11);
      ql = 1'b1;
      r0 = reqs;
      cmd(`OP_SECTOR_ERASE, 3, 24'h00ABCD, 0, 0, 0);
      chk({reqs - r0, erase_base}, {32'h1, 24'h00A000});
      idle();
      write_enable_cmd();
      cmd(`OP_FOUR_LINE_EXIT, 0, 0, 0, 0, 0);
      ql = 1'b0;
      chk({four_line, write_enable_latch}, 2'b01);
      $display("test 6 done");
      end_of_test();
   end
endmodule // serial_flash_erase_program_test
bind serial_flash_erase_program serial_flash_erase_program_props props_inst (
   .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_cs_n(i_cs_n),
   .i_protect_level(i_protect_level), .i_mem_ready(i_mem_ready),
   .o_mem_valid(o_mem_valid), .o_mem_addr(o_mem_addr),
   .o_mem_data(o_mem_data), .o_erase_req(o_erase_req),
   .o_erase_kind(o_erase_kind), .o_erase_base(o_erase_base),
   .o_write_in_progress(o_write_in_progress),
   .o_write_enable_latch(o_write_enable_latch));
`default_nettype wire
